/* logic/scg_crc16_consts.svh */
// constants for the serial crc16 generator/checker
`ifndef SCG_CRC16_CONSTS_SVH
`define SCG_CRC16_CONSTS_SVH
// axi4-lite register byte offsets
`define SCG_OFS_CTRL 4'h0
`define SCG_OFS_STATUS 4'h4
`define SCG_OFS_REMAIN 4'h8
// ctrl fields
`define SCG_CTRL_READ_MODE 0
`define SCG_CTRL_SOFT_INIT 1
`define SCG_CTRL_RST 2'h0
// status fields
`define SCG_ST_GOOD 0
`define SCG_ST_SKIP 1
`define SCG_ST_SEL 2
`define SCG_ST_FLAG_N 3
// crc
`define SCG_CRC_PRESET 16'hFFFF
`define SCG_CRC_POLY 16'h1021
// divider
`define SCG_DIV_W 4
`define SCG_DIV_HALF 4'h7
// pin vector positions
`define SCG_P_DIN 0
`define SCG_P_BBC 1
`define SCG_P_SHF 2
`define SCG_P_SEL 3
`define SCG_P_INIT 4
`define SCG_P_WCLK 5
`define SCG_NPIN 6
// axi responses
`define SCG_RESP_OKAY 2'h0
`define SCG_RESP_SLVERR 2'h2
`endif

/* logic/scg_pkg.sv */
// types for the serial crc16 generator/checker
package scg_pkg;
  typedef logic [15:0] scg_crc_t;
  typedef logic [31:0] scg_word_t;
  typedef logic [3:0] scg_addr_t;
  typedef logic [1:0] scg_resp_t;
endpackage

/* logic/scg_crc16_top.sv */
// serial crc16 generator/checker with axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`include "scg_crc16_consts.svh"
// Overview of operation
// - active-low serial input feeds generate and check
// - byte clock fall latches data/check select
// - shift clock fall advances one bit
// - write, select low: shift check word out
// - read: shift rise sets good when zero
// - flag low during check word output
// - init low: skip high, register all ones
// - write: data passes unaltered, check appended
// - first falling input clears skip, arms
// - good held while input high, no init
// - second good output is complement
// - write clock divided by sixteen
// - after check word output rests high
// - write-side output logic idle in read mode
// - polynomial x16 + x12 + x5 + 1
module scg_crc16_top (
  // system
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire scg_pkg::scg_addr_t s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire scg_pkg::scg_word_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output scg_pkg::scg_resp_t s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire scg_pkg::scg_addr_t s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output scg_pkg::scg_word_t s_axi_rdata,
  output scg_pkg::scg_resp_t s_axi_rresp,
  // serial pins in
  input wire logic data_in_n,
  input wire logic byte_boundary_clock,
  input wire logic bit_shift_clock,
  input wire logic data_or_check_select,
  input wire logic check_init_n,
  input wire logic write_clock,
  // serial pins out
  output logic data_out_n,
  output logic skip_gate,
  output logic checkword_out_flag_n,
  output logic check_good,
  output logic check_good_n,
  output logic divided_step_clock
);
  import scg_pkg::*;
  function automatic logic fell(input logic prev, input logic cur);
    fell = prev & ~cur;
  endfunction
  function automatic scg_crc_t crc_step(input scg_crc_t c, input logic din_n);
    logic fb;
    fb = c[15] ^ ~din_n;
    crc_step = {c[14:0], 1'b0} ^ (fb ? `SCG_CRC_POLY : 16'h0000);
  endfunction
  // pin synchronisers
  logic [`SCG_NPIN-1:0] pin_raw;
  logic [`SCG_NPIN-1:0] meta_ff;
  logic [`SCG_NPIN-1:0] sync_ff;
  logic [`SCG_NPIN-1:0] prev_ff;
  assign pin_raw = {write_clock, check_init_n, data_or_check_select,
                    bit_shift_clock, byte_boundary_clock, data_in_n};
  genvar gi;
  generate
    for (gi = 0; gi < `SCG_NPIN; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          meta_ff[gi] <= 1'b1;
          sync_ff[gi] <= 1'b1;
          prev_ff[gi] <= 1'b1;
        end else begin
          meta_ff[gi] <= pin_raw[gi];
          sync_ff[gi] <= meta_ff[gi];
          prev_ff[gi] <= sync_ff[gi];
        end
      end
    end
  endgenerate
  // registers and core state
  logic read_mode_ff;
  logic soft_init_ff;
  logic skip_ff;
  logic sel_ff;
  scg_crc_t crc_ff;
  logic dout_n_ff;
  logic flag_n_ff;
  logic good_ff;
  logic good_n_ff;
  logic nxt_good;
  logic [`SCG_DIV_W-1:0] div_cnt_ff;

  logic din_s;
  logic init;
  logic din_fall;
  logic bbc_fall;
  logic shf_fall;
  logic shf_rise;
  logic wclk_rise;
  logic shift_en;

  assign din_s = sync_ff[`SCG_P_DIN];
  assign init = ~sync_ff[`SCG_P_INIT] | soft_init_ff;
  assign din_fall = fell(prev_ff[`SCG_P_DIN], sync_ff[`SCG_P_DIN]);
  assign bbc_fall = fell(prev_ff[`SCG_P_BBC], sync_ff[`SCG_P_BBC]);
  assign shf_fall = fell(prev_ff[`SCG_P_SHF], sync_ff[`SCG_P_SHF]);
  assign shf_rise = fell(sync_ff[`SCG_P_SHF], prev_ff[`SCG_P_SHF]);
  assign wclk_rise = fell(sync_ff[`SCG_P_WCLK], prev_ff[`SCG_P_WCLK]);
  // armed once skip is low, or on the very bit that clears it
  assign shift_en = ~skip_ff | ~din_s;

  // skip gate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_ff <= 1'b1;
    end else if (init) begin
      skip_ff <= 1'b1;
    end else if (din_fall) begin
      skip_ff <= 1'b0;
    end
  end

  // latched data/check select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_ff <= 1'b1;
    end else if (bbc_fall) begin
      sel_ff <= sync_ff[`SCG_P_SEL];
    end
  end

  // check register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      crc_ff <= `SCG_CRC_PRESET;
    end else if (init) begin
      crc_ff <= `SCG_CRC_PRESET;
    end else if (shf_fall) begin
      if (!read_mode_ff && !sel_ff) begin
        crc_ff <= {crc_ff[14:0], 1'b0};
      end else if (shift_en) begin
        crc_ff <= crc_step(crc_ff, din_s);
      end
    end
  end

  // serial output and checkword flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dout_n_ff <= 1'b1;
      flag_n_ff <= 1'b1;
    end else if (read_mode_ff) begin
      dout_n_ff <= 1'b1;
      flag_n_ff <= 1'b1;
    end else begin
      dout_n_ff <= sel_ff ? din_s : ~crc_ff[15];
      flag_n_ff <= sel_ff;
    end
  end

  // check good flags
  always_comb begin
    nxt_good = good_ff;
    if (init || !read_mode_ff) begin
      nxt_good = 1'b0;
    end else if (shf_rise && !skip_ff && crc_ff == 16'h0000) begin
      nxt_good = 1'b1;
    end else if (!din_s) begin
      nxt_good = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      good_ff <= 1'b0;
      good_n_ff <= 1'b1;
    end else begin
      good_ff <= nxt_good;
      good_n_ff <= ~nxt_good;
    end
  end

  // timing clock divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_ff <= 4'h0;
    end else if (wclk_rise) begin
      div_cnt_ff <= 4'(div_cnt_ff + 4'h1);
    end
  end

  assign data_out_n = dout_n_ff;
  assign skip_gate = skip_ff;
  assign checkword_out_flag_n = flag_n_ff;
  assign check_good = good_ff;
  assign check_good_n = good_n_ff;
  assign divided_step_clock = div_cnt_ff[`SCG_DIV_W-1];

  // axi4-lite write path
  logic aw_got_ff;
  logic w_got_ff;
  scg_addr_t awaddr_ff;
  scg_word_t wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  scg_resp_t bresp_ff;
  logic have_aw;
  logic have_w;
  scg_addr_t wr_addr;
  scg_word_t wr_data;
  logic [3:0] wr_strb;
  logic wr_do;

  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
  assign have_aw = aw_got_ff | (s_axi_awvalid & s_axi_awready);
  assign have_w = w_got_ff | (s_axi_wvalid & s_axi_wready);
  assign wr_do = have_aw & have_w & ~bvalid_ff;
  assign wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  assign wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
  assign wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 4'h0;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
    end else if (wr_do) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `SCG_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_addr == `SCG_OFS_CTRL) ? `SCG_RESP_OKAY : `SCG_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {soft_init_ff, read_mode_ff} <= `SCG_CTRL_RST;
    end else if (wr_do && wr_addr == `SCG_OFS_CTRL && wr_strb[0]) begin
      read_mode_ff <= wr_data[`SCG_CTRL_READ_MODE];
      soft_init_ff <= wr_data[`SCG_CTRL_SOFT_INIT];
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // axi4-lite read path
  logic rvalid_ff;
  scg_word_t rdata_ff;
  scg_resp_t rresp_ff;
  scg_word_t rd_mux;
  scg_resp_t rd_resp;

  assign s_axi_arready = ~rvalid_ff;

  always_comb begin
    rd_mux = 32'h00000000;
    rd_resp = `SCG_RESP_OKAY;
    case (s_axi_araddr)
      `SCG_OFS_CTRL: begin
        rd_mux[`SCG_CTRL_READ_MODE] = read_mode_ff;
        rd_mux[`SCG_CTRL_SOFT_INIT] = soft_init_ff;
      end
      `SCG_OFS_STATUS: begin
        rd_mux[`SCG_ST_GOOD] = good_ff;
        rd_mux[`SCG_ST_SKIP] = skip_ff;
        rd_mux[`SCG_ST_SEL] = sel_ff;
        rd_mux[`SCG_ST_FLAG_N] = flag_n_ff;
      end
      `SCG_OFS_REMAIN: begin
        rd_mux[15:0] = crc_ff;
      end
      default: begin
        rd_resp = `SCG_RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `SCG_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_INIT_PRESET: assert property (init |=> crc_ff == 16'hFFFF && skip_gate)
    else $error("init did not preset register and skip");
  AST_SKIP_ARM: assert property (!init && din_fall |=> !skip_gate)
    else $error("falling input did not clear skip");
  AST_SEL_LATCH: assert property (bbc_fall |=> sel_ff == $past(sync_ff[`SCG_P_SEL]))
    else $error("select not latched on byte clock");
  AST_SHIFT: assert property (!init && shf_fall && shift_en && (read_mode_ff || sel_ff)
    |=> crc_ff == crc_step($past(crc_ff), $past(din_s)))
    else $error("register did not advance one bit");
  AST_CW_OUT: assert property (!read_mode_ff && !sel_ff
    |=> data_out_n == !$past(crc_ff[15]) && !checkword_out_flag_n)
    else $error("check word bit not on output");
  AST_PASS: assert property (!read_mode_ff && sel_ff |=> data_out_n == $past(din_s) && checkword_out_flag_n)
    else $error("data not passed through");
  AST_READ_IDLE: assert property (read_mode_ff ##1 read_mode_ff |-> data_out_n && checkword_out_flag_n)
    else $error("write path active in read mode");
  AST_GOOD_SET: assert property (read_mode_ff && !init && shf_rise && !skip_gate && crc_ff == 16'h0000
    |=> check_good)
    else $error("good not set on zero remainder");
  AST_GOOD_HOLD: assert property (check_good && din_s && !init && read_mode_ff |=> check_good)
    else $error("good dropped while input high");
  AST_GOOD_COMPL: assert property (check_good_n == !check_good)
    else $error("good outputs not complementary");
  AST_DIV: assert property (wclk_rise && div_cnt_ff == `SCG_DIV_HALF |=> $rose(divided_step_clock))
    else $error("divider edge misplaced");
endmodule // scg_crc16_top

/* verification/scg_ctl_model.sv */
// controller-side model: framing, serial bits and byte clocks toward the crc block
`timescale 1ns/1ps
module scg_ctl_model (
  // clock
  input wire logic aclk,
  // serial pins toward the block
  output logic din_n,
  output logic bbc,
  output logic shf,
  output logic sel,
  output logic init_n
);
  logic [1:0] exp_q[$];
  initial begin
    din_n = 1'b1;
    bbc = 1'b1;
    shf = 1'b1;
    sel = 1'b1;
    init_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic init();
    @(posedge aclk);
    init_n <= 1'b0;
    tick(6);
    init_n <= 1'b1;
    tick(6);
  endtask
  // one bit period: rise, optional byte clock pulse, then the shifting fall
  task automatic bitp(input logic d, input logic b, input logic s, input logic [1:0] e);
    @(posedge aclk);
    din_n <= d;
    shf <= 1'b1;
    bbc <= ~b;
    sel <= s;
    tick(4);
    bbc <= 1'b1;
    tick(4);
    exp_q.push_back(e);
    shf <= 1'b0;
    tick(7);
  endtask
  task automatic frame(input logic [7:0] dat[$], input logic rd, input logic bad);
    logic [15:0] c;
    int j;
    int k;
    c = 16'hFFFF;
    for (k = 0; k < 8; k++) begin
      bitp(1'b1, k == 0, 1'b1, 2'b11);
    end
    for (j = 0; j < dat.size(); j++) begin
      for (k = 7; k >= 0; k--) begin
        c = {c[14:0], 1'b0} ^ ((c[15] ^ dat[j][k]) ? 16'h1021 : 16'h0000);
        bitp(~dat[j][k], k == 7, j < dat.size() - 1 || k == 7, {~dat[j][k] | rd, 1'b1});
      end
    end
    for (k = 15; k >= 0; k--) begin
      bitp(rd ? ~(c[k] ^ (bad && k == 0)) : 1'b1, k % 8 == 7, 1'b0, rd ? 2'b11 : {~c[k], 1'b0});
    end
    for (k = 0; k < 8; k++) begin
      bitp(1'b1, k == 0, k != 0, {1'b1, rd});
    end
    @(posedge aclk);
    shf <= 1'b1;
    tick(8);
  endtask
endmodule // scg_ctl_model

/* verification/scg_crc16_top_tb.sv */
// self-checking bench for the serial crc16 generator/checker
`timescale 1ns/1ps
`include "scg_crc16_consts.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; $display("ERROR %0t mismatch", $time); end end
module scg_crc16_top_tb;
  import scg_pkg::*;
  logic aclk, awr, wr, bv, arr, rv, dout_n, skip, flag_n, good, good_n, dclk;
  logic aresetn = 1'b0, awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, wclk = 1'b1;
  wire din_n, bbc, shf, sel, init_n;
  scg_addr_t awa = 4'h0, ara = 4'h0;
  scg_word_t wd = 32'h00000000, rdat;
  scg_resp_t bresp, rresp;
  logic [31:0] rnd = 32'h9639B327;
  logic [7:0] q[$];
  int fails = 0, check_count = 0, tog = 0, nw = 0, seen = -1, i, k;
  scg_crc16_top scg_crc16_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bresp), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdat), .s_axi_rresp(rresp), .data_in_n(din_n), .byte_boundary_clock(bbc), .bit_shift_clock(shf),
    .data_or_check_select(sel), .check_init_n(init_n), .write_clock(wclk), .data_out_n(dout_n), .skip_gate(skip),
    .checkword_out_flag_n(flag_n), .check_good(good), .check_good_n(good_n), .divided_step_clock(dclk));
  scg_ctl_model scg_ctl_model_i (.aclk(aclk), .din_n(din_n), .bbc(bbc), .shf(shf), .sel(sel), .init_n(init_n));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic results();
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // one axi4-lite write (w=1) or read (w=0), response and read data compared
  task automatic ax(input logic w, input scg_addr_t a, input scg_word_t d, input scg_resp_t e);
    logic pa;
    logic pw;
    logic pb;
    int n;
    pa = 1'b1;
    pw = w;
    pb = 1'b1;
    @(posedge aclk);
    awa <= a;
    ara <= a;
    wd <= d;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= ~w;
    rr <= ~w;
    for (n = 0; n < 50 && pb; n++) begin
      @(posedge aclk);
      if (pa && (w ? awr : arr)) begin
        pa = 1'b0;
        awv <= 1'b0;
        arv <= 1'b0;
      end
      if (pw && wr) begin
        pw = 1'b0;
        wv <= 1'b0;
      end
      if (w ? bv : rv) begin
        pb = 1'b0;
        br <= 1'b0;
        rr <= 1'b0;
        `CHK(w ? bresp : rresp, e)
        if (!w) `CHK(rdat, d)
      end
    end
    if (pb) begin
      fails++;
      results();
    end
  endtask
  task automatic mkq();
    q.delete();
    for (k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      q.push_back(k == 0 ? rnd[7:0] | 8'h80 : rnd[7:0]);
    end
  endtask
  // write clock at one tenth of aclk
  always @(posedge aclk) begin
    tog <= (tog == 4) ? 0 : tog + 1;
    if (tog == 4) wclk <= ~wclk;
  end
  always @(posedge wclk) nw++;
  always @(posedge dclk) begin
    if (seen >= 0) `CHK(nw - seen, 16)
    seen = nw;
  end
  // serial output and flag against the noted bit at each shifting fall
  always @(negedge shf) begin
    if (scg_ctl_model_i.exp_q.size() > 0) begin
      `CHK({dout_n, flag_n}, scg_ctl_model_i.exp_q.pop_front())
    end
  end
  initial begin
    repeat (100000) @(posedge aclk);
    fails++;
    results();
  end
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    ax(1'b0, `SCG_OFS_STATUS, 32'h0000000E, `SCG_RESP_OKAY);
    ax(1'b0, 4'hC, 32'h00000000, `SCG_RESP_SLVERR);
    ax(1'b1, `SCG_OFS_REMAIN, 32'h00000000, `SCG_RESP_SLVERR);
    scg_ctl_model_i.init();
    ax(1'b0, `SCG_OFS_REMAIN, 32'h0000FFFF, `SCG_RESP_OKAY);
    `CHK(skip, 1'b1)
    mkq();
    scg_ctl_model_i.frame(q, 1'b0, 1'b0);
    `CHK(skip, 1'b0)
    `CHK({good, good_n}, 2'b01)
    ax(1'b1, `SCG_OFS_CTRL, 32'h00000001, `SCG_RESP_OKAY);
    mkq();
    for (i = 0; i < 2; i++) begin
      scg_ctl_model_i.init();
      scg_ctl_model_i.frame(q, 1'b1, i == 0);
      `CHK(good, i == 1)
      `CHK(good_n, i == 0)
    end
    ax(1'b0, `SCG_OFS_REMAIN, 32'h00000000, `SCG_RESP_OKAY);
    scg_ctl_model_i.bitp(1'b0, 1'b0, 1'b1, 2'b11);
    `CHK(good, 1'b0)
    ax(1'b1, `SCG_OFS_CTRL, 32'h00000003, `SCG_RESP_OKAY);
    ax(1'b0, `SCG_OFS_REMAIN, 32'h0000FFFF, `SCG_RESP_OKAY);
    `CHK(skip, 1'b1)
    results();
  end
endmodule // scg_crc16_top_tb
